// ### core/rcr_pkg.sv
package rcr_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_CTRL = 4'h3;
  localparam logic [3:0] ADDR_WREG = 4'h4;

  // ==========================================================
  // Flag bit positions
  // ==========================================================
  localparam int BIT_TRAP = 15;
  localparam int BIT_ILL = 14;
  localparam int BIT_CM = 9;
  localparam int BIT_EXT = 7;
  localparam int BIT_SW = 6;
  localparam int BIT_WDT = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_IDLE = 2;
  localparam int BIT_BOR = 1;
  localparam int BIT_POR = 0;

  localparam logic [15:0] FLAGS_IMPL = 16'hc2df;
  localparam logic [15:0] FLAGS_RESET = 16'h0003;

  // ==========================================================
  // Decode constants
  // ==========================================================
  localparam logic [3:0] HARD_PRIO_MIN = 4'hd;
  localparam logic [3:0] HARD_PRIO_MAX = 4'hf;
  localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;
  localparam int NUM_WREG = 16;
  localparam logic [3:0] STACK_PTR_IDX = 4'hf;

  // Status event bits (interrupt layout)
  localparam int EV_TRAP = 0;
  localparam int EV_CM = 1;
  localparam int EV_ILL = 2;
  localparam int EV_SEC = 3;
  localparam int EV_W = 4;

  typedef struct packed {
    logic valid;
    logic [23:0] target;
    logic is_vector;
  } rcr_flow_t;

  typedef struct packed {
    logic fetch_valid;
    logic [23:0] word;
  } rcr_fetch_t;

endpackage : rcr_pkg

// ### core/rcr_shadow_cmp.sv
`timescale 1ns/1ps
// Shadow copy of one pin-select register; flags unexpected difference
module rcr_shadow_cmp #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] live_i,
  output logic mismatch_o
);
  logic [W-1:0] shadow_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shadow_q <= '0;
    end else if (load_i) begin
      shadow_q <= wdata_i;
    end
  end

  // A legal write updates both copies in the same cycle
  assign mismatch_o = !load_i && (shadow_q != live_i);
endmodule : rcr_shadow_cmp

// ### core/rcr_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Lower-priority hard trap during higher-priority service causes reset.
// - Hard traps are priority levels 13 to 15; address 13, oscillator 14.
// - Trap conflict reset sets flag bit 15.
// - Pin-select registers compared to shadow copies; difference resets.
// - Mismatch reset sets flag bit 9; feature may be absent.
// - Illegal opcode, uninitialized pointer, security fault reset; bit 14.
// - Executing an illegal opcode word from program memory resets device.
// - Instruction word with upper byte 0x3f is illegal.
// - Reset clears registers except 15; uninitialized pointer use resets.
// - Flow change to restricted protected location causes security reset.
// - Program flow change detected on call, jump, return or branch.
// - Vector flow change detected when PC loads interrupt or trap vector.
// - Pin, instruction, watchdog, sleep, idle, power events set own flags.
// - Power clears flags; pin flag only power-on; watchdog also cleared.
// - Software writes can set or clear every implemented flag bit (FLAGS_IMPL, 0xc2df; bit 9 only when CM_PRESENT); other bits stay zero.
module rcr_top #(
  parameter int NUM_PPS = 4,
  parameter int PPS_W = 16,
  parameter bit CM_PRESENT = 1'b1,
  parameter logic [23:0] SEC_LO = 24'h000200,
  parameter logic [23:0] SEC_HI = 24'h0003ff,
  parameter logic [23:0] SEC_ENTRY = 24'h000200
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Power domain resets: pulses from the supply monitors
  input wire logic por_i,
  input wire logic bor_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic reset_instr_i,
  input wire logic wdt_timeout_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic power_save_sleep_i,
  input wire logic power_save_idle_i,
  // Trap reporting from the core
  input wire logic trap_new_i,
  input wire logic [3:0] trap_prio_i,
  input wire logic [3:0] trap_active_prio_i,
  input wire logic trap_in_service_i,
  // Instruction pipeline
  input wire rcr_pkg::rcr_fetch_t exec_i,
  input wire logic wreg_write_i,
  input wire logic [3:0] wreg_waddr_i,
  input wire logic ptr_use_i,
  input wire logic [3:0] ptr_idx_i,
  input wire rcr_pkg::rcr_flow_t flow_i,
  // Pin-select configuration
  input wire logic [NUM_PPS-1:0] pps_write_i,
  input wire logic [PPS_W-1:0] pps_wdata_i,
  input wire logic [NUM_PPS*PPS_W-1:0] pps_live_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  output logic sys_reset_o,
  output logic irq_o
);

  // ==========================================================
  // Synchronisers for pin and asynchronous sources
  // ==========================================================
  logic [1:0] ext_sync_q;
  logic [1:0] wdt_sync_q;
  logic ext_prev_q;
  logic wdt_prev_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_sync_q <= 2'b11;
      wdt_sync_q <= 2'b00;
      ext_prev_q <= 1'b1;
      wdt_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_reset_pin_n_i};
      wdt_sync_q <= {wdt_sync_q[0], wdt_timeout_i};
      ext_prev_q <= ext_sync_q[1];
      wdt_prev_q <= wdt_sync_q[1];
    end
  end

  // Reset levels equal the idle pin levels: no false edge
  wire ext_ev = ext_prev_q && !ext_sync_q[1];
  wire wdt_ev = !wdt_prev_q && wdt_sync_q[1];
  wire pwr_ev = por_i || bor_i;

  // ==========================================================
  // Trap conflict
  // ==========================================================
  // hard trap range
  wire new_hard = (trap_prio_i >= rcr_pkg::HARD_PRIO_MIN) &&
                  (trap_prio_i <= rcr_pkg::HARD_PRIO_MAX);
  wire trap_ev = trap_new_i && new_hard && trap_in_service_i &&
                 (trap_prio_i < trap_active_prio_i);

  // ==========================================================
  // Pin-select shadow compare
  // ==========================================================
  logic [NUM_PPS-1:0] pps_mis;

  genvar g;
  generate
    for (g = 0; g < NUM_PPS; g++) begin : g_shadow
      rcr_shadow_cmp #(
        .W(PPS_W)
      ) u_cmp (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .load_i(pps_write_i[g]),
        .wdata_i(pps_wdata_i),
        .live_i(pps_live_i[g*PPS_W +: PPS_W]),
        .mismatch_o(pps_mis[g])
      );
    end
  endgenerate

  wire cm_ev = CM_PRESENT && (|pps_mis);

  // ==========================================================
  // Illegal conditions
  // ==========================================================
  // illegal opcode
  wire opc_ev = exec_i.fetch_valid &&
                (exec_i.word[23:16] == rcr_pkg::ILLEGAL_OPCODE);

  logic [rcr_pkg::NUM_WREG-1:0] winit_q;
  logic [rcr_pkg::NUM_WREG-1:0] winit_set;
  always_comb begin
    winit_set = '0;
    winit_set[wreg_waddr_i] = wreg_write_i;
  end
  wire w_ev = ptr_use_i && !winit_q[ptr_idx_i];

  wire program_flow_change = flow_i.valid && !flow_i.is_vector;
  wire vector_flow_change = flow_i.valid && flow_i.is_vector;
  wire in_seg = (flow_i.target >= SEC_LO) && (flow_i.target <= SEC_HI);
  wire restricted = in_seg && (flow_i.target != SEC_ENTRY);
  wire sec_ev = (program_flow_change || vector_flow_change) && restricted;

  wire ill_ev = opc_ev || w_ev || sec_ev;

  // ==========================================================
  // Merged reset request
  // ==========================================================
  // single request
  wire any_req = trap_ev || cm_ev || ill_ev || ext_ev ||
                 reset_instr_i || wdt_ev;
  logic sys_reset_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= any_req || pwr_ev;
    end
  end
  assign sys_reset_o = sys_reset_q;

  // ==========================================================
  // Working-register initialisation map
  // ==========================================================
  // clear on every reset, stack pointer kept
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      winit_q <= '0;
    end else if (sys_reset_q) begin
      winit_q <= '0;
      winit_q[rcr_pkg::STACK_PTR_IDX] <= 1'b1;
    end else begin
      winit_q <= winit_q | winit_set;
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  wire wr_flags = reg_we_i && (reg_addr_i == rcr_pkg::ADDR_FLAGS);
  wire wr_stat = reg_we_i && (reg_addr_i == rcr_pkg::ADDR_STATUS);
  wire wr_mask = reg_we_i && (reg_addr_i == rcr_pkg::ADDR_MASK);
  wire wr_ctrl = reg_we_i && (reg_addr_i == rcr_pkg::ADDR_CTRL);

  // ==========================================================
  // Flag masks
  // ==========================================================
  // Without the shadow checker its flag stays zero
  logic [15:0] impl_mask;
  // Flags that a brown-out leaves alone
  logic [15:0] bor_keep;

  always_comb begin
    impl_mask = rcr_pkg::FLAGS_IMPL;
    if (!CM_PRESENT) begin
      impl_mask[rcr_pkg::BIT_CM] = 1'b0;
    end
    bor_keep = '0;
    bor_keep[rcr_pkg::BIT_EXT] = 1'b1;
    bor_keep[rcr_pkg::BIT_BOR] = 1'b1;
    bor_keep[rcr_pkg::BIT_POR] = 1'b1;
  end

  // ==========================================================
  // Reset-cause flags
  // ==========================================================
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] set_v;
  logic [15:0] clr_v;

  always_comb begin
    set_v = '0;
    set_v[rcr_pkg::BIT_TRAP] = trap_ev;
    set_v[rcr_pkg::BIT_ILL] = ill_ev;
    set_v[rcr_pkg::BIT_CM] = cm_ev;
    set_v[rcr_pkg::BIT_EXT] = ext_ev;
    set_v[rcr_pkg::BIT_SW] = reset_instr_i;
    set_v[rcr_pkg::BIT_WDT] = wdt_ev;
    set_v[rcr_pkg::BIT_SLEEP] = power_save_sleep_i;
    set_v[rcr_pkg::BIT_IDLE] = power_save_idle_i;
    set_v[rcr_pkg::BIT_BOR] = pwr_ev;
    set_v[rcr_pkg::BIT_POR] = por_i;
    clr_v = '0;
    if (pwr_ev) begin
      clr_v = impl_mask & ~bor_keep;
    end
    if (por_i) begin
      clr_v[rcr_pkg::BIT_EXT] = 1'b1;
    end
    if (watchdog_clear_instruction_i || power_save_sleep_i ||
        power_save_idle_i) begin
      clr_v[rcr_pkg::BIT_WDT] = 1'b1;
    end
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = reg_wdata_i & impl_mask;
    end
    // Hardware events win over a same-cycle write
    flags_d = (flags_d & ~clr_v) | set_v;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= rcr_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // Interrupt status, mask, control
  // ==========================================================
  logic [4:0] stat_q;
  logic [4:0] mask_q;
  logic cm_en_q;
  logic [4:0] ev_v;

  // ==========================================================
  // Status events
  // ==========================================================
  always_comb begin
    ev_v = '0;
    ev_v[rcr_pkg::EV_TRAP] = trap_ev;
    ev_v[rcr_pkg::EV_CM] = cm_ev;
    ev_v[rcr_pkg::EV_ILL] = ill_ev;
    ev_v[rcr_pkg::EV_SEC] = sec_ev;
    ev_v[rcr_pkg::EV_W] = w_ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= '0;
      mask_q <= '0;
      cm_en_q <= 1'b1;
    end else begin
      // Set wins over write-one-to-clear
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata_i[4:0] : 5'h00)) | ev_v;
      if (wr_mask) begin
        mask_q <= reg_wdata_i[4:0];
      end
      if (wr_ctrl) begin
        cm_en_q <= reg_wdata_i[0];
      end
    end
  end

  // ==========================================================
  // Interrupt output
  // ==========================================================
  // Level output: high until software clears or masks the bit
  assign irq_o = |(stat_q & mask_q);

  // ==========================================================
  // Read port
  // ==========================================================
  logic [15:0] rd_mux;
  logic [15:0] rdata_q;

  always_comb begin
    case (reg_addr_i)
      rcr_pkg::ADDR_FLAGS: rd_mux = flags_q;
      rcr_pkg::ADDR_STATUS: rd_mux = {11'h000, stat_q};
      rcr_pkg::ADDR_MASK: rd_mux = {11'h000, mask_q};
      rcr_pkg::ADDR_CTRL: rd_mux = {15'h0000, cm_en_q};
      rcr_pkg::ADDR_WREG: rd_mux = winit_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ==========================================================
  // Read data register
  // ==========================================================
  // Zero outside the answer cycle, so stale data never lingers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (reg_re_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata_o = rdata_q;

endmodule : rcr_top

// ### bench/rcr_asserts.sv
`timescale 1ns/1ps
// ====================
// Reset request checks
module rcr_asserts #(
  parameter logic [23:0] SEC_LO = 24'h000200,
  parameter logic [23:0] SEC_HI = 24'h0003ff,
  parameter logic [23:0] SEC_ENTRY = 24'h000200
) (
  input logic clk_i,
  input logic rstn_i,
  input logic ext_reset_pin_n_i,
  input logic reset_instr_i,
  input logic wdt_timeout_i,
  input logic trap_new_i,
  input logic [3:0] trap_prio_i,
  input logic [3:0] trap_active_prio_i,
  input logic trap_in_service_i,
  input rcr_pkg::rcr_fetch_t exec_i,
  input rcr_pkg::rcr_flow_t flow_i,
  input logic reg_re_i,
  input logic [15:0] reg_rdata_o,
  input logic sys_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire in_sec = flow_i.target >= SEC_LO && flow_i.target <= SEC_HI;
  wire sec_hit = flow_i.valid && in_sec && flow_i.target != SEC_ENTRY;
  // Pin and watchdog pass a synchroniser first
  sequence s_ext;
    $fell(ext_reset_pin_n_i);
  endsequence
  sequence s_wdt;
    $rose(wdt_timeout_i);
  endsequence
  property p_trap;
    trap_new_i && trap_in_service_i && trap_prio_i >= 4'hd &&
      trap_prio_i < trap_active_prio_i |=> sys_reset_o;
  endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_opc;
    exec_i.fetch_valid && exec_i.word[23:16] == 8'h3f |=> sys_reset_o;
  endproperty
  a_opc: assert property (p_opc) else $error("opcode");
  property p_pfc;
    sec_hit && !flow_i.is_vector |=> sys_reset_o;
  endproperty
  a_pfc: assert property (p_pfc) else $error("pfc");
  property p_vfc;
    sec_hit && flow_i.is_vector |=> sys_reset_o;
  endproperty
  a_vfc: assert property (p_vfc) else $error("vfc");
  property p_swr;
    reset_instr_i |=> sys_reset_o;
  endproperty
  a_swr: assert property (p_swr) else $error("swr");
  property p_ext;
    s_ext |-> ##[1:4] sys_reset_o;
  endproperty
  a_ext: assert property (p_ext) else $error("ext");
  property p_wdt;
    s_wdt |-> ##[1:4] sys_reset_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt");
  property p_rd;
    !reg_re_i |=> reg_rdata_o == 16'h0000;
  endproperty
  a_rd: assert property (p_rd) else $error("rdata");
endmodule : rcr_asserts

// ### bench/rcr_core_model.sv
`timescale 1ns/1ps
// ====================
// Core side requests
module rcr_core_model (
  input logic clk_i,
  output logic [3:0] ins_o,
  output logic tn_o,
  output logic ts_o,
  output logic [3:0] tp_o,
  output logic [3:0] ta_o,
  output rcr_pkg::rcr_fetch_t ex_o,
  output logic ww_o,
  output logic [3:0] wa_o,
  output logic pu_o,
  output logic [3:0] pi_o,
  output rcr_pkg::rcr_flow_t fl_o
);
  initial begin
    {ins_o, tn_o, ts_o, tp_o, ta_o, ww_o, wa_o, pu_o, pi_o} = '0;
    ex_o = '0;
    fl_o = '0;
  end
  // One request per call; fetch word and flow target inverted once invalid, other operands held
  task go(input int k, input logic [23:0] v);
    @(posedge clk_i);
    case (k)
      0: {tn_o, ts_o, tp_o, ta_o} <= {2'b11, v[7:0]};
      1: ex_o <= {1'b1, v};
      2, 3: fl_o <= {1'b1, v, k == 3};
      4: {pu_o, pi_o} <= {1'b1, v[3:0]};
      5: {ww_o, wa_o} <= {1'b1, v[3:0]};
      default: ins_o[k-6] <= 1'b1;
    endcase
    @(posedge clk_i);
    {ins_o, tn_o, ts_o, ww_o, pu_o} <= '0;
    ex_o <= {1'b0, ~v};
    fl_o <= {1'b0, ~v, 1'b0};
  endtask : go
endmodule : rcr_core_model

// ### bench/rcr_top_bench.sv
`timescale 1ns/1ps
// ====================
// Reset cause bench
module rcr_top_bench;
  localparam logic [3:0] AF = rcr_pkg::ADDR_FLAGS;
  localparam logic [3:0] AS = rcr_pkg::ADDR_STATUS;
  localparam logic [3:0] AM = rcr_pkg::ADDR_MASK;
  logic clk_i, rstn_i, por_i, bor_i, ext_reset_pin_n_i, wdt_timeout_i;
  logic reg_we_i, reg_re_i, sys_reset_o, irq_o, seen, tn, ts, ww, pu;
  logic [3:0] ins, tp, ta, wa, pi, reg_addr_i, pps_write_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, pps_wdata_i;
  logic [63:0] pps_live_i;
  rcr_pkg::rcr_fetch_t ex;
  rcr_pkg::rcr_flow_t fl;
  int fails, num_checks;
  rcr_top u_rcr_top (.clk_i, .rstn_i, .por_i, .bor_i, .ext_reset_pin_n_i,
    .reset_instr_i(ins[0]), .watchdog_clear_instruction_i(ins[1]),
    .power_save_sleep_i(ins[2]), .power_save_idle_i(ins[3]),
    .wdt_timeout_i, .trap_new_i(tn), .trap_prio_i(tp),
    .trap_active_prio_i(ta), .trap_in_service_i(ts), .exec_i(ex),
    .wreg_write_i(ww), .wreg_waddr_i(wa), .ptr_use_i(pu), .ptr_idx_i(pi),
    .flow_i(fl), .pps_write_i, .pps_wdata_i, .pps_live_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .sys_reset_o, .irq_o);
  rcr_core_model u_rcr_core_model (.clk_i, .ins_o(ins), .tn_o(tn),
    .ts_o(ts), .tp_o(tp), .ta_o(ta), .ex_o(ex), .ww_o(ww), .wa_o(wa),
    .pu_o(pu), .pi_o(pi), .fl_o(fl));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sys_reset_o) seen <= 1'b1;
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {reg_we_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    {reg_re_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk($sformatf("reg %0h", a), e, reg_rdata_o);
  endtask : rd
  task fire(input int k, input logic [23:0] v, input logic [15:0] f,
            input logic [15:0] s, input logic r);
    seen = 1'b0;
    @(posedge clk_i);
    if (k == 10) ext_reset_pin_n_i <= 1'b0;
    if (k == 11) wdt_timeout_i <= 1'b1;
    if (k == 12) pps_live_i[15:0] <= 16'h5a5a;
    if (k == 13)
      {pps_write_i[1], pps_wdata_i, pps_live_i[31:16]} <= {1'b1, 32'h12341234};
    if (k < 10) u_rcr_core_model.go(k, v);
    repeat (4) @(posedge clk_i);
    {ext_reset_pin_n_i, wdt_timeout_i, pps_live_i[15:0]} <= {2'b10, 16'h0};
    pps_write_i <= '0;
    repeat (4) @(posedge clk_i);
    #1 chk("sys_reset", {15'h0, r}, {15'h0, seen});
    rd(AF, f);
    rd(AS, s);
    wr(AF, 16'h0000);
    wr(AS, 16'h001f);
  endtask : fire
  task pw(input int k, input logic [15:0] p, input logic [15:0] e);
    wr(AF, p);
    if (k < 10) u_rcr_core_model.go(k, 24'h0);
    else begin
      @(posedge clk_i);
      {por_i, bor_i} <= (k == 10) ? 2'b10 : 2'b01;
      @(posedge clk_i);
      {por_i, bor_i} <= 2'b00;
    end
    rd(AF, e);
  endtask : pw
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    {rstn_i, por_i, bor_i, wdt_timeout_i, reg_we_i, reg_re_i, seen} = '0;
    {ext_reset_pin_n_i, reg_addr_i, reg_wdata_i} = {1'b1, 20'h0};
    {pps_write_i, pps_wdata_i, pps_live_i} = '0;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(AF, 16'h0003);
    rd(AS, 16'h0000);
    rd(rcr_pkg::ADDR_CTRL, 16'h0001);
    rd(rcr_pkg::ADDR_WREG, 16'h8000);
    wr(AF, 16'hffff);
    rd(AF, 16'hc2df);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    wr(AF, 16'h0000);
    rd(AF, 16'h0000);
    $display("test registers done");
    fire(0, 24'h0000de, 16'h8000, 16'h0001, 1'b1);
    fire(0, 24'h0000ef, 16'h8000, 16'h0001, 1'b1);
    fire(0, 24'h0000cf, 16'h0000, 16'h0000, 1'b0);
    fire(0, 24'h0000fd, 16'h0000, 16'h0000, 1'b0);
    fire(1, 24'h3f0000, 16'h4000, 16'h0004, 1'b1);
    fire(1, 24'h3effff, 16'h0000, 16'h0000, 1'b0);
    fire(2, 24'h000201, 16'h4000, 16'h000c, 1'b1);
    fire(3, 24'h0003ff, 16'h4000, 16'h000c, 1'b1);
    fire(2, 24'h000200, 16'h0000, 16'h0000, 1'b0);
    fire(3, 24'h000400, 16'h0000, 16'h0000, 1'b0);
    fire(4, 24'h000003, 16'h4000, 16'h0014, 1'b1);
    u_rcr_core_model.go(5, 24'h000003);
    fire(4, 24'h000003, 16'h0000, 16'h0000, 1'b0);
    fire(4, 24'h00000f, 16'h0000, 16'h0000, 1'b0);
    fire(6, 24'h0, 16'h0040, 16'h0000, 1'b1);
    fire(8, 24'h0, 16'h0008, 16'h0000, 1'b0);
    fire(9, 24'h0, 16'h0004, 16'h0000, 1'b0);
    fire(10, 24'h0, 16'h0080, 16'h0000, 1'b1);
    fire(11, 24'h0, 16'h0010, 16'h0000, 1'b1);
    fire(12, 24'h0, 16'h0200, 16'h0002, 1'b1);
    fire(13, 24'h0, 16'h0000, 16'h0000, 1'b0);
    $display("test events done");
    pw(11, 16'hc2df, 16'h0083);
    pw(10, 16'hc2df, 16'h0003);
    pw(7, 16'hc2df, 16'hc2cf);
    pw(8, 16'h0010, 16'h0008);
    pw(9, 16'h0010, 16'h0004);
    wr(AF, 16'h0000);
    $display("test power done");
    wr(AM, 16'h0001);
    u_rcr_core_model.go(0, 24'h0000de);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", 16'h0001, {15'h0, irq_o});
    wr(AM, 16'h0000);
    #1 chk("irq", 16'h0000, {15'h0, irq_o});
    wr(AM, 16'h0001);
    wr(AS, 16'h0001);
    #1 chk("irq", 16'h0000, {15'h0, irq_o});
    $display("test interrupt done");
    end_sim;
  end
endmodule : rcr_top_bench
bind rcr_top rcr_asserts #(.SEC_LO(SEC_LO), .SEC_HI(SEC_HI),
  .SEC_ENTRY(SEC_ENTRY)) u_rcr_asserts (.clk_i(clk_i), .rstn_i(rstn_i),
  .ext_reset_pin_n_i(ext_reset_pin_n_i), .reset_instr_i(reset_instr_i),
  .wdt_timeout_i(wdt_timeout_i), .trap_new_i(trap_new_i),
  .trap_prio_i(trap_prio_i), .trap_active_prio_i(trap_active_prio_i),
  .trap_in_service_i(trap_in_service_i), .exec_i(exec_i), .flow_i(flow_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .sys_reset_o(sys_reset_o));
